// *** fch_host_ctrl.sv ***
// fch_host_ctrl: apb-programmed host that issues command sequences to a
// parallel nor flash and follows its write status by data polling.
// assumes an external pull-up on the ready/busy line and a single flash.
//
// Function
// R1: array read is one plain read cycle, no command writes.
// R2: reset op writes F0 once, to leave autoselect or a failure.
// R3: timeout flag high while still busy: host writes reset.
// R4: autoselect writes AA, 55, 90, then reads at the offset.
// R5: autoselect read at sector offset 02 gives 00h or 01h.
// R6: program is AA, 55, A0, then address with data.
// R7: address and data stable across the whole strobe pulse.
// R8: AA, 55, 20 enters unlock bypass; bypass program is A0, data.
// R9: leaving unlock bypass writes 90 then 00.
// R10: sector erase is AA, 55, 80, AA, 55, 30 at sector address.
// R11: suspend writes B0; honoured only during sector erase.
// R12: resume writes 30; accepted only while suspended.
// R13: reads, programs, autoselect allowed while erase is suspended.
// R14: unlock and command cycles drive a fixed address.
// R15: program polling compares bit 7 with written bit 7.
// R16: protected program target: brief busy polling, then array reads.
// R17: erase polling waits for bit 7 to read one.
// R18: all-protected erase: busy polling about 100 us, then array reads.
// R19: after bit 7 turns true, a further read fetches valid data.
// R20: polling starts right after the last write.
// R21: ready/busy low while programming or erasing, else high.
// R22: ready/busy is open drain; only sampled here.
// R23: chip erase is AA, 55, 80, AA, 55, 10.
// R24: more sectors may be added within 50 us before erase starts.
// R25: an unexpected code abandons a partial sequence.
//
// Implementation choices: the register addresses and the APB register port.
module fch_host_ctrl
	import fch_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	output fch_pins_t               flash_o,
	input  wire logic [DATA_W-1:0]  dq_i,
	input  wire logic               ready_busy_n
);
	// ----------------------------------------
	// sequence table
	// ----------------------------------------
	function automatic fch_step_t seq_step(fch_op_t op, logic [2:0] idx,
		logic [DATA_W-1:0] wd);
		fch_step_t s;
		s = '{last: 1'b0, is_read: 1'b0, use_addr: 1'b0, data: CODE_UNLOCK1};
		if (idx == 3'd1 || idx == 3'd4)
			s.data = CODE_UNLOCK2;
		unique case (op)
			OP_READ, OP_POLL_ERASE: begin // R1
				s.is_read  = 1'b1;
				s.use_addr = 1'b1;
				s.last     = 1'b1;
			end
			OP_RESET: begin // R2
				s.data = CODE_RESET;
				s.last = 1'b1;
			end
			OP_AUTOSEL: begin // R4
				if (idx == 3'd2)
					s.data = CODE_AUTOSEL;
				if (idx == 3'd3) begin // R5
					s.is_read  = 1'b1;
					s.use_addr = 1'b1;
					s.last     = 1'b1;
				end
			end
			OP_PROG: begin // R6
				if (idx == 3'd2)
					s.data = CODE_PROGRAM;
				if (idx == 3'd3) begin
					s.data     = wd;
					s.use_addr = 1'b1;
					s.last     = 1'b1;
				end
			end
			OP_UB_ENTER: begin // R8
				if (idx == 3'd2) begin
					s.data = CODE_UB_ENTER;
					s.last = 1'b1;
				end
			end
			OP_UB_PROG: begin // R8
				s.data = CODE_PROGRAM;
				if (idx == 3'd1) begin
					s.data     = wd;
					s.use_addr = 1'b1;
					s.last     = 1'b1;
				end
			end
			OP_UB_EXIT: begin // R9
				s.data = (idx == 3'd0) ? CODE_UB_EXIT1 : CODE_UB_EXIT2;
				s.last = (idx == 3'd1);
			end
			OP_CHIP_ERASE, OP_SECT_ERASE: begin // R10 R23
				if (idx == 3'd2)
					s.data = CODE_ERASE_SETUP;
				if (idx == 3'd5) begin
					s.data     = (op == OP_SECT_ERASE) ? CODE_SECT_ERASE : CODE_CHIP_ERASE;
					s.use_addr = (op == OP_SECT_ERASE);
					s.last     = 1'b1;
				end
			end
			OP_SECT_ADD: begin // R24
				s.data     = CODE_SECT_ERASE;
				s.use_addr = 1'b1;
				s.last     = 1'b1;
			end
			OP_SUSPEND: begin // R11
				s.data = CODE_SUSPEND;
				s.last = 1'b1;
			end
			OP_RESUME: begin // R12
				s.data = CODE_RESUME;
				s.last = 1'b1;
			end
			default: begin
				s.data = CODE_RESET;
				s.last = 1'b1;
			end
		endcase
		return s;
	endfunction : seq_step

	function automatic logic op_polls(fch_op_t op, logic defer);
		return (op == OP_PROG) || (op == OP_UB_PROG) || (op == OP_CHIP_ERASE) ||
			(op == OP_POLL_ERASE) || (op == OP_SECT_ERASE && !defer); // R24
	endfunction : op_polls

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [8:0] {
		S_IDLE  = 9'b0_0000_0001,
		S_SEQ   = 9'b0_0000_0010,
		S_SEQW  = 9'b0_0000_0100,
		S_POLL  = 9'b0_0000_1000,
		S_POLLW = 9'b0_0001_0000,
		S_FIN   = 9'b0_0010_0000,
		S_FINW  = 9'b0_0100_0000,
		S_ABT   = 9'b0_1000_0000,
		S_ABTW  = 9'b1_0000_0000
	} fch_state_t;

	fch_state_t        state_ff;
	fch_state_t        nxt_state;
	fch_op_t           op_ff;
	logic              defer_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [2:0]        idx_ff;
	logic              recheck_ff;
	logic              done_ff;
	logic              fail_ff;
	logic [31:0]       prdata_ff;
	logic              pready_ff;
	logic              pslverr_ff;

	logic [DATA_W:0]   sync_q;
	logic              eng_done;
	logic [DATA_W-1:0] eng_rdata;

	// ----------------------------------------
	// pin synchronisers and bus cycle engine
	// ----------------------------------------
	// ready/busy only sampled: wired-and line with a pull-up
	fch_sync #(.W(DATA_W + 1)) u_sync ( // R22
		.mclk  (mclk),
		.rst_n (rst_n),
		.d     ({ready_busy_n, dq_i}),
		.q     (sync_q)
	);

	wire [DATA_W-1:0] dq_sync  = sync_q[DATA_W-1:0];
	wire              rdy_sync = sync_q[DATA_W];
	wire fch_step_t   step     = seq_step(op_ff, idx_ff, wdata_ff);

	wire poll_exp  = (op_ff == OP_PROG || op_ff == OP_UB_PROG) ?
		wdata_ff[POLL_STATUS_BIT] : 1'b1; // R15 R17
	wire poll_hit  = (eng_rdata[POLL_STATUS_BIT] == poll_exp);
	wire eng_req   = (state_ff == S_SEQ) || (state_ff == S_POLL) ||
		(state_ff == S_FIN) || (state_ff == S_ABT);
	wire eng_rd    = (state_ff == S_SEQ) ? step.is_read : (state_ff != S_ABT);
	wire use_addr  = (state_ff == S_SEQ) ? step.use_addr : (state_ff != S_ABT);
	wire [ADDR_W-1:0] eng_addr = use_addr ? addr_ff : ADDR_RST; // R14
	wire [DATA_W-1:0] eng_data = (state_ff == S_ABT) ? CODE_RESET : step.data;

	fch_bus_cycle u_cycle (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.req     (eng_req),
		.is_read (eng_rd),
		.addr    (eng_addr),
		.data    (eng_data),
		.dq_sync (dq_sync),
		.pins    (flash_o),
		.done    (eng_done),
		.rdata   (eng_rdata)
	);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire apb_setup  = psel & ~penable;
	wire apb_access = psel & penable & pready_ff;
	wire apb_wr     = apb_access & pwrite;
	wire addr_hit   = (paddr == REG_CMD) || (paddr == REG_ADDR) ||
		(paddr == REG_WDATA) || (paddr == REG_STATUS);
	wire idle       = (state_ff == S_IDLE);
	wire op_legal   = (pwdata[CMD_OP_LSB +: CMD_OP_W] <= OP_LAST);
	// commands while busy dropped: a sequence is never cut
	wire start      = apb_wr && paddr == REG_CMD && idle && op_legal; // R25
	wire stat_wr    = apb_wr && paddr == REG_STATUS;

	wire [31:0] status_word = {16'h0000, rdata_ff, 4'h0, rdy_sync, // R21
		fail_ff, done_ff, ~idle};
	wire [31:0] rd_mux =
		(paddr == REG_CMD)    ? {27'h000_0000, defer_ff, op_ff} :
		(paddr == REG_ADDR)   ? {12'h000, addr_ff} :
		(paddr == REG_WDATA)  ? {24'h00_0000, wdata_ff} :
		(paddr == REG_STATUS) ? status_word : WORD_ZERO;

	// sticky flags: set beats clear
	wire set_done = (state_ff == S_SEQW && eng_done && step.last &&
		!op_polls(op_ff, defer_ff)) ||
		((state_ff == S_FINW || state_ff == S_ABTW) && eng_done);
	wire set_fail = (state_ff == S_ABTW) && eng_done;
	wire nxt_done = set_done | (done_ff & ~(stat_wr & pwdata[STAT_DONE_BIT]));
	wire nxt_fail = set_fail | (fail_ff & ~(stat_wr & pwdata[STAT_FAIL_BIT]));

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// no host-side poll timeout: protected targets end busy on their own
	always_comb begin // R16 R18
		nxt_state = state_ff;
		unique case (state_ff)
			S_IDLE:  if (start) nxt_state = S_SEQ; // R13
			S_SEQ:   nxt_state = S_SEQW;
			S_SEQW:  if (eng_done) begin
				if (!step.last)
					nxt_state = S_SEQ;
				else if (op_polls(op_ff, defer_ff))
					nxt_state = S_POLL; // R20
				else
					nxt_state = S_IDLE;
			end
			S_POLL:  nxt_state = S_POLLW;
			S_POLLW: if (eng_done) begin
				if (poll_hit)
					nxt_state = S_FIN; // R19
				else if (recheck_ff)
					nxt_state = S_ABT; // R3
				else
					nxt_state = S_POLL;
			end
			S_FIN:   nxt_state = S_FINW;
			S_FINW:  if (eng_done) nxt_state = S_IDLE;
			S_ABT:   nxt_state = S_ABTW;
			S_ABTW:  if (eng_done) nxt_state = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			state_ff <= S_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			idx_ff     <= 3'd0;
			recheck_ff <= 1'b0;
			rdata_ff   <= DATA_RST;
		end else begin
			if (start) begin
				idx_ff     <= 3'd0;
				recheck_ff <= 1'b0;
			end
			if (state_ff == S_SEQW && eng_done) begin
				idx_ff <= idx_ff + 3'd1;
				if (step.is_read)
					rdata_ff <= eng_rdata;
			end
			// recheck once: bit 7 may turn true with the timeout flag
			if (state_ff == S_POLLW && eng_done)
				recheck_ff <= eng_rdata[TIMEOUT_FAIL_BIT]; // R3
			if (state_ff == S_FINW && eng_done)
				rdata_ff <= eng_rdata; // R19
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			op_ff    <= OP_READ;
			defer_ff <= 1'b0;
			addr_ff  <= ADDR_RST;
			wdata_ff <= DATA_RST;
		end else if (apb_wr && idle) begin
			if (start) begin
				op_ff    <= fch_op_t'(pwdata[CMD_OP_LSB +: CMD_OP_W]);
				defer_ff <= pwdata[CMD_DEFER_BIT];
			end
			if (paddr == REG_ADDR)
				addr_ff <= pwdata[ADDR_W-1:0];
			if (paddr == REG_WDATA)
				wdata_ff <= pwdata[DATA_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done_ff    <= 1'b0;
			fail_ff    <= 1'b0;
			prdata_ff  <= WORD_ZERO;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			done_ff    <= nxt_done;
			fail_ff    <= nxt_fail;
			pready_ff  <= apb_setup;
			pslverr_ff <= apb_setup & ~addr_hit;
			prdata_ff  <= (apb_setup & ~pwrite) ? rd_mux : WORD_ZERO;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
endmodule : fch_host_ctrl

// *** fch_pkg.sv ***
// fch_pkg: constants, codes and carriers for the parallel flash host controller.
// assumes a 250 MHz mclk and a byte-wide asynchronous flash on the far side.
package fch_pkg;

	// ----------------------------------------
	// clock and bus timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_SETUP_NS    = 20;
	localparam int T_WRPULSE_NS  = 40;
	// read pulse covers access time plus the two-flop input delay
	localparam int T_RDPULSE_NS  = 100;
	localparam int T_HOLD_NS     = 20;
	localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRPULSE_CYC   = (T_WRPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RDPULSE_CYC   = (T_RDPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC      = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ADDR_W  = 20;
	localparam int DATA_W  = 8;
	localparam int PADDR_W = 12;
	localparam int CNT_W   = 8;

	// ----------------------------------------
	// register map and fields
	// ----------------------------------------
	localparam logic [PADDR_W-1:0] REG_CMD    = 12'h000;
	localparam logic [PADDR_W-1:0] REG_ADDR   = 12'h004;
	localparam logic [PADDR_W-1:0] REG_WDATA  = 12'h008;
	localparam logic [PADDR_W-1:0] REG_STATUS = 12'h00C;
	localparam int CMD_OP_LSB      = 0;
	localparam int CMD_OP_W        = 4;
	localparam int CMD_DEFER_BIT   = 4;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_DONE_BIT   = 1;
	localparam int STAT_FAIL_BIT   = 2;
	localparam int STAT_READY_BIT  = 3;
	localparam int STAT_RDATA_LSB  = 8;
	localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h0_0000;
	localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;
	localparam logic [31:0]       WORD_ZERO = 32'h0000_0000;

	// ----------------------------------------
	// flash command codes and status bits
	// ----------------------------------------
	localparam logic [DATA_W-1:0] CODE_UNLOCK1     = 8'hAA;
	localparam logic [DATA_W-1:0] CODE_UNLOCK2     = 8'h55;
	localparam logic [DATA_W-1:0] CODE_AUTOSEL     = 8'h90;
	localparam logic [DATA_W-1:0] CODE_PROGRAM     = 8'hA0;
	localparam logic [DATA_W-1:0] CODE_UB_ENTER    = 8'h20;
	localparam logic [DATA_W-1:0] CODE_UB_EXIT1    = 8'h90;
	localparam logic [DATA_W-1:0] CODE_UB_EXIT2    = 8'h00;
	localparam logic [DATA_W-1:0] CODE_ERASE_SETUP = 8'h80;
	localparam logic [DATA_W-1:0] CODE_CHIP_ERASE  = 8'h10;
	localparam logic [DATA_W-1:0] CODE_SECT_ERASE  = 8'h30;
	localparam logic [DATA_W-1:0] CODE_SUSPEND     = 8'hB0;
	localparam logic [DATA_W-1:0] CODE_RESUME      = 8'h30;
	localparam logic [DATA_W-1:0] CODE_RESET       = 8'hF0;
	localparam int POLL_STATUS_BIT   = 7;
	localparam int TIMEOUT_FAIL_BIT  = 5;

	typedef enum logic [CMD_OP_W-1:0] {
		OP_READ       = 4'h0,
		OP_RESET      = 4'h1,
		OP_AUTOSEL    = 4'h2,
		OP_PROG       = 4'h3,
		OP_UB_ENTER   = 4'h4,
		OP_UB_PROG    = 4'h5,
		OP_UB_EXIT    = 4'h6,
		OP_CHIP_ERASE = 4'h7,
		OP_SECT_ERASE = 4'h8,
		OP_SECT_ADD   = 4'h9,
		OP_SUSPEND    = 4'hA,
		OP_RESUME     = 4'hB,
		OP_POLL_ERASE = 4'hC
	} fch_op_t;
	localparam logic [CMD_OP_W-1:0] OP_LAST = 4'hC;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic              ce_n;
		logic              we_n;
		logic              oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_o;
		logic              dq_oe;
	} fch_pins_t;

	typedef struct packed {
		logic              last;
		logic              is_read;
		logic              use_addr;
		logic [DATA_W-1:0] data;
	} fch_step_t;

endpackage : fch_pkg

// *** fch_sync.sv ***
// fch_sync: two-flop synchroniser for pin inputs.
// assumes each bit is an independent level; no multi-bit coherence.
module fch_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule : fch_sync

// *** fch_bus_cycle.sv ***
// fch_bus_cycle: one read or write cycle on the flash pins.
// assumes dq_sync is the two-flop copy of the data pins.
module fch_bus_cycle
	import fch_pkg::*;
#(
	parameter int SETUP_N   = SETUP_CYC,
	parameter int WRPULSE_N = WRPULSE_CYC,
	parameter int RDPULSE_N = RDPULSE_CYC,
	parameter int HOLD_N    = HOLD_CYC
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              req,
	input  wire logic              is_read,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] data,
	input  wire logic [DATA_W-1:0] dq_sync,
	output fch_pins_t              pins,
	output logic                   done,
	output logic      [DATA_W-1:0] rdata
);
	typedef enum logic [3:0] {
		PH_IDLE  = 4'b0001,
		PH_SETUP = 4'b0010,
		PH_PULSE = 4'b0100,
		PH_HOLD  = 4'b1000
	} fch_phase_t;

	fch_phase_t        ph_ff;
	logic              rd_ff;
	logic [CNT_W-1:0]  cnt_ff;
	fch_pins_t         pins_ff;
	logic              done_ff;
	logic [DATA_W-1:0] rdata_ff;

	wire [CNT_W-1:0] pulse_end = rd_ff ? CNT_W'(RDPULSE_N - 1) : CNT_W'(WRPULSE_N - 1);
	wire             setup_end = (cnt_ff == CNT_W'(SETUP_N - 1));
	wire             pulse_last = (cnt_ff == pulse_end);
	wire             hold_end  = (cnt_ff == CNT_W'(HOLD_N - 1));

	// addr and data held from setup to hold: both latch edges see them
	always_ff @(posedge mclk or negedge rst_n) begin // R7
		if (!rst_n) begin
			ph_ff    <= PH_IDLE;
			rd_ff    <= 1'b0;
			cnt_ff   <= '0;
			pins_ff  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: ADDR_RST,
				dq_o: DATA_RST, dq_oe: 1'b0};
			done_ff  <= 1'b0;
			rdata_ff <= DATA_RST;
		end else begin
			done_ff <= 1'b0;
			cnt_ff  <= cnt_ff + CNT_W'(1);
			unique case (ph_ff)
				PH_IDLE: if (req) begin
					ph_ff         <= PH_SETUP;
					rd_ff         <= is_read;
					cnt_ff        <= '0;
					pins_ff.addr  <= addr;
					pins_ff.dq_o  <= data;
					pins_ff.dq_oe <= ~is_read;
				end
				PH_SETUP: if (setup_end) begin
					ph_ff        <= PH_PULSE;
					cnt_ff       <= '0;
					pins_ff.ce_n <= 1'b0;
					pins_ff.we_n <= rd_ff;
					pins_ff.oe_n <= ~rd_ff;
				end
				PH_PULSE: if (pulse_last) begin
					ph_ff        <= PH_HOLD;
					cnt_ff       <= '0;
					pins_ff.ce_n <= 1'b1;
					pins_ff.we_n <= 1'b1;
					pins_ff.oe_n <= 1'b1;
					if (rd_ff)
						rdata_ff <= dq_sync;
				end
				PH_HOLD: if (hold_end) begin
					ph_ff         <= PH_IDLE;
					pins_ff.dq_oe <= 1'b0;
					done_ff       <= 1'b1;
				end
			endcase
		end
	end

	assign pins  = pins_ff;
	assign done  = done_ff;
	assign rdata = rdata_ff;
endmodule : fch_bus_cycle

// *** fch_host_ctrl_chk.sv ***
// fch_host_ctrl_chk: apb answer and flash strobe timing checks on fch_host_ctrl.
// assumes the single mclk domain with rst_n as its only reset.
module fch_host_ctrl_chk
	import fch_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire fch_pins_t   flash_o
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	property p_ans;
		psel && !penable |=> pready && penable;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer in access cycle");

	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error outside access cycle");

	property p_idle;
		!pready |-> prdata == WORD_ZERO;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside access");

	property p_rdoff;
		!flash_o.oe_n |-> !flash_o.dq_oe && flash_o.we_n;
	endproperty
	a_rdoff: assert property (p_rdoff) else $error("data pins driven in read");

	property p_rdlen;
		$fell(flash_o.oe_n) |-> ##24 !flash_o.oe_n ##1 flash_o.oe_n;
	endproperty
	a_rdlen: assert property (p_rdlen) else $error("read pulse length");

	property p_wrlen;
		$fell(flash_o.we_n) |-> !flash_o.we_n [*8] ##1 !flash_o.we_n [*2] ##1 flash_o.we_n;
	endproperty
	a_wrlen: assert property (p_wrlen) else $error("write pulse length");

	property p_setup;
		$fell(flash_o.we_n) |-> !flash_o.ce_n && $past(flash_o.dq_oe, 3) && $stable(flash_o.addr);
	endproperty
	a_setup: assert property (p_setup) else $error("write setup broken");

	property p_wstab;
		!flash_o.we_n && $past(!flash_o.we_n) |-> $stable(flash_o.addr) && $stable(flash_o.dq_o);
	endproperty
	a_wstab: assert property (p_wstab) else $error("bus moved in write pulse");

	property p_hold;
		$rose(flash_o.we_n) |-> flash_o.dq_oe && $stable(flash_o.addr) && $stable(flash_o.dq_o);
	endproperty
	a_hold: assert property (p_hold) else $error("write hold broken");

	property p_unlk;
		$fell(flash_o.we_n) && flash_o.dq_o == CODE_UNLOCK1 |-> flash_o.addr == ADDR_RST;
	endproperty
	a_unlk: assert property (p_unlk) else $error("unlock address not fixed");
endmodule : fch_host_ctrl_chk

bind fch_host_ctrl fch_host_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_o(flash_o));

// *** fch_flash_model.sv ***
// fch_flash_model: behavioural byte-wide nor flash with its command state machine.
// assumes erase starts at once, with no add-sector window.
module fch_flash_model
	import fch_pkg::*;
#(
	parameter int         PROG_NS   = 2000,
	parameter int         ERASE_NS  = 8000,
	parameter logic [6:0] PROT_SECT = 7'h05,
	parameter logic [7:0] MAKER_ID  = 8'h5A,  // arbitrary
	parameter logic [7:0] DEV_ID    = 8'hC3   // arbitrary
) (
	input  wire logic              ce_n,
	input  wire logic              we_n,
	input  wire logic              oe_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] din,
	input  wire logic              fail_mode,
	output logic      [DATA_W-1:0] dout,
	output logic                   rb_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [0:(1<<20)-1];
	logic [19:0] a_lat = '0, pa = '0;
	logic [7:0]  pd = '0, last = '0;
	int          seq = 0, busy = 0, asel = 0, ub = 0, ubx = 0, pg = 0, susp = 0, esect = 0, tleft = 0;

	initial begin
		foreach (mem[i])
			mem[i] = 8'hFF;
	end
	// open drain: only pulls the line low
	assign rb_oe = busy != 0;

	function automatic logic [7:0] rd(input logic [19:0] a);
		if (asel)
			return a[1:0] == 2'h0 ? MAKER_ID : a[1:0] == 2'h1 ? DEV_ID :
				{7'h00, a[19:13] == PROT_SECT};
		if (busy == 1 && a == pa)
			return {~pd[7], 1'b0, fail_mode, 5'h00};
		if ((busy == 2 || susp != 0) && (esect == 128 || int'(a[19:13]) == esect))
			return {susp[0], 7'h00};
		return mem[a];
	endfunction : rd

	// released bus shows the inverse, never a stale byte
	always @(ce_n or oe_n or addr or busy or asel or susp) begin
		if (!ce_n && !oe_n)
			last = rd(addr);
		dout = (!ce_n && !oe_n) ? last : ~last;
	end

	wire wstb = !ce_n && !we_n;
	always @(posedge wstb)
		a_lat = addr;
	always @(negedge wstb)
		wr(a_lat, din);

	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		if (busy == 2 && esect != 128 && d == CODE_SUSPEND) begin
			busy = 0;
			susp = 1;
		end else if (busy == 1 && fail_mode && d == CODE_RESET)
			busy = 0;
		else if (busy != 0)
			;
		else if (pg != 0) begin
			pg = 0;
			pa = a;
			pd = d;
			busy = 1;
			tleft = a[19:13] == PROT_SECT ? 1000 : PROG_NS;
		end else if (ub != 0) begin
			pg = d == CODE_PROGRAM;
			ub = !(ubx != 0 && d == CODE_UB_EXIT2);
			ubx = d == CODE_UB_EXIT1;
		end else if (d == CODE_RESET) begin
			asel = 0;
			seq = 0;
		end else if (seq == 0 && susp != 0 && d == CODE_RESUME) begin
			susp = 0;
			busy = 2;
		end else if ((seq == 0 || seq == 3) && d == CODE_UNLOCK1)
			seq++;
		else if ((seq == 1 || seq == 4) && d == CODE_UNLOCK2)
			seq++;
		else if (seq == 2 && d == CODE_AUTOSEL) begin
			asel = 1;
			seq = 0;
		end else if (seq == 2 && d == CODE_PROGRAM) begin
			pg = 1;
			seq = 0;
		end else if (seq == 2 && susp == 0 && d == CODE_UB_ENTER) begin
			ub = 1;
			seq = 0;
		end else if (seq == 2 && susp == 0 && d == CODE_ERASE_SETUP)
			seq = 3;
		else if (seq == 5 && (d == CODE_CHIP_ERASE || d == CODE_SECT_ERASE)) begin
			esect = d == CODE_CHIP_ERASE ? 128 : int'(a[19:13]);
			busy = 2;
			seq = 0;
			tleft = esect == int'(PROT_SECT) ? 100000 : ERASE_NS;
		end else
			seq = 0;
	endtask : wr

	always #4 begin
		if (busy != 0 && !(fail_mode && busy == 1)) begin
			if (tleft > 0)
				tleft = tleft - 4;
			else begin
				if (busy == 1 && pa[19:13] != PROT_SECT)
					mem[pa] = pd;
				for (int i = 0; busy == 2 && i < (1 << 20); i++)
					if ((esect == 128 || i[19:13] == esect) && i[19:13] != PROT_SECT)
						mem[i] = 8'hFF;
				busy = 0;
			end
		end
	end
endmodule : fch_flash_model

// *** fch_host_ctrl_bench.sv ***
// fch_host_ctrl_bench: drives the controller over apb against the flash model.
// assumes the model ids and protected sector given here, and a pull-up on ready/busy.
module fch_host_ctrl_bench
	import fch_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0]  MAKER = 8'h5A;  // arbitrary
	localparam logic [7:0]  DEVID = 8'hC3;  // arbitrary
	localparam logic [6:0]  PSEC  = 7'h05;
	localparam logic [19:0] ASA [4] = '{20'h0_0000, 20'h0_0001, {PSEC, 13'h0002}, 20'h0_0002};
	localparam logic [7:0]  ASE [4] = '{MAKER, DEVID, 8'h01, 8'h00};
	logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fmode = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, err, rb_oe, rbl;
	logic [7:0]  fl_dout, d;
	fch_pins_t   flash_o;
	logic [7:0]  bm [int];
	logic [19:0] pa [6];
	int          err_total = 0, checks = 0, seed = 49, cyc = 0;
	wire logic [7:0] dq_i = flash_o.dq_oe ? flash_o.dq_o : fl_dout;
	wire logic       ready_busy_n = !rb_oe;

	always #2 mclk = ~mclk;

	fch_host_ctrl dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_o(flash_o), .dq_i(dq_i), .ready_busy_n(ready_busy_n));
	fch_flash_model #(.PROT_SECT(PSEC), .MAKER_ID(MAKER), .DEV_ID(DEVID)) fl (.ce_n(flash_o.ce_n),
		.we_n(flash_o.we_n), .oe_n(flash_o.oe_n), .addr(flash_o.addr), .din(dq_i),
		.fail_mode(fmode), .dout(fl_dout), .rb_oe(rb_oe));

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_total++;
			final_report();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd = WORD_ZERO);
		@(posedge mclk);
		psel    <= 1;
		penable <= 0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 0;
		penable <= 0;
	endtask : apb

	// clears done and fail, then waits out busy
	task automatic op(input logic [4:0] c, input logic [19:0] a = 20'h0_0000,
		input logic [7:0] dv = 8'h00);
		apb(1, REG_ADDR, 32'(a));
		apb(1, REG_WDATA, 32'(dv));
		apb(1, REG_STATUS, 32'h0000_0006);
		apb(1, REG_CMD, 32'(c));
		do begin
			apb(0, REG_STATUS);
			if (rd[3] === 1'b0)
				rbl = 1;
		end while (rd[0] !== 1'b0);
	endtask : op

	task automatic rdall(input string n);
		for (int i = 0; i < 6; i++) begin
			op(5'h00, pa[i]);
			chk(n, bm.exists(pa[i]) ? bm[pa[i]] : 8'hFF, rd[15:8]);
		end
		$display("test %s done", n);
	endtask : rdall

	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1;
		apb(0, 12'h010);
		chk("unmapped", 32'h0000_0001, 32'(err));
		chk("unmapped_data", WORD_ZERO, rd);
		apb(0, REG_STATUS);
		chk("status", 32'h0000_0008, rd);
		for (int i = 0; i < 6; i++) begin
			pa[i] = 20'($random(seed));
			pa[i][19:13] = 7'(i + 8);
			// odd data is never 00 or any command code except 55
			d = 8'($random(seed)) | 8'h01;
			rbl = 0;
			if (i == 4)
				op(5'h04);
			op(i < 4 ? 5'h03 : 5'h05, pa[i], d);
			bm[pa[i]] = d;
			chk("prog_status", 32'h0000_000A, rd[3:0]);
			chk("prog_data", d, rd[15:8]);
			chk("busy_line", 32'h0000_0001, rbl);
		end
		op(5'h06);
		foreach (ASA[k]) begin
			op(5'h02, ASA[k]);
			chk("autoselect", ASE[k], rd[15:8]);
		end
		op(5'h01);
		rdall("program");
		op(5'h08, pa[1]);
		bm.delete(pa[1]);
		rdall("sector erase");
		op(5'h18, pa[2]);
		op(5'h0A);
		op(5'h00, pa[2]);
		chk("suspend_poll", 32'h0000_0001, rd[15]);
		op(5'h03, pa[3], 8'h3F);
		bm[pa[3]] = 8'h3F;
		op(5'h0B);
		op(5'h0C, pa[2]);
		bm.delete(pa[2]);
		rdall("suspend");
		fmode <= 1;
		op(5'h03, pa[0], 8'h01);
		chk("fail_status", 32'h0000_0006, rd[2:0]);
		fmode <= 0;
		rdall("fail");
		op(5'h07);
		bm.delete();
		rdall("chip erase");
		op(5'h03, {PSEC, 13'h0010}, 8'h81);
		chk("prot_prog", 32'h0000_00FF, rd[15:8]);
		apb(1, REG_STATUS, 32'h0000_0006);
		apb(1, REG_CMD, 32'h0000_000D);
		apb(0, REG_STATUS);
		chk("illegal_op", 32'h0000_0008, rd[7:0]);
		$display("test registers done");
		final_report();
	end
endmodule : fch_host_ctrl_bench
